/* include/fbg_pkg.sv */
package fbg_pkg;

  // host register offsets
  localparam logic [3:0] FBG_OFS_TX_HOLD     = 4'h0;
  localparam logic [3:0] FBG_OFS_LINE_CTRL   = 4'h1;
  localparam logic [3:0] FBG_OFS_DIV_LOW     = 4'h2;
  localparam logic [3:0] FBG_OFS_DIV_HIGH    = 4'h3;
  localparam logic [3:0] FBG_OFS_DIV_FRAC    = 4'h4;
  localparam logic [3:0] FBG_OFS_LINE_STATUS = 4'h5;
  localparam logic [3:0] FBG_OFS_MODEM_CTRL  = 4'h6;
  localparam logic [3:0] FBG_OFS_EIGHT_X     = 4'h7;
  localparam logic [3:0] FBG_OFS_FOUR_X      = 4'h8;

  // values after reset, and the mode enable code
  localparam logic [7:0] FBG_RST_DIV_LOW   = 8'h01;
  localparam logic [7:0] FBG_RST_DIV_HIGH  = 8'h00;
  localparam logic [7:0] FBG_RST_DIV_FRAC  = 8'h00;
  localparam logic [7:0] FBG_RST_MODE      = 8'h00;
  localparam logic [7:0] FBG_RST_MODEM     = 8'h00;
  localparam logic [7:0] FBG_RST_LINE_CTRL = 8'h03;
  localparam logic [7:0] FBG_MODE_ON       = 8'hFF;

  // field positions
  localparam int FBG_MCR_PRESC_BIT = 7;
  localparam int FBG_LSR_THRE_BIT  = 5;
  localparam int FBG_LSR_TEMT_BIT  = 6;
  localparam int FBG_LCR_STOP2_BIT = 2;
  localparam int FBG_LCR_PAR_BIT   = 3;
  localparam int FBG_LCR_EVEN_BIT  = 4;
  localparam int FBG_FRAC_W        = 4;

  // cycle counts
  localparam logic [1:0] FBG_PRESC_LAST = 2'h3;
  localparam logic [4:0] FBG_OVS_16     = 5'h10;
  localparam logic [4:0] FBG_OVS_8      = 5'h08;
  localparam logic [4:0] FBG_OVS_4      = 5'h04;

  // transmit storage
  localparam int         FBG_FIFO_DEPTH = 16;
  localparam int         FBG_PTR_W      = 4;
  localparam logic [4:0] FBG_FIFO_FULL  = 5'h10;
  localparam logic [1:0] FBG_BUF_FULL   = 2'h2;

  typedef enum logic [2:0] {
    FBG_TX_IDLE,
    FBG_TX_START,
    FBG_TX_DATA,
    FBG_TX_PARITY,
    FBG_TX_STOP
  } fbg_tx_state_t;

endpackage

/* design/fbg_baud_gen.sv */
`timescale 1ns/1ps
module fbg_baud_gen (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  // prescaled clock and divisor
  input  wire logic                           prescTick,
  input  wire logic [15:0]                    divInt,
  input  wire logic [fbg_pkg::FBG_FRAC_W-1:0] divFrac,
  // sampling clock pulse
  output logic                                sampleTick
);
  import fbg_pkg::*;

  logic [16:0] cnt_ff;
  logic [16:0] len_ff;
  logic [3:0]  acc_ff;
  logic        tick_ff;
  logic [16:0] effInt;
  logic [4:0]  nxt_acc;
  logic        periodEnd;

  // a zero integer part behaves as one
  assign effInt    = (divInt == 16'h0000) ? 17'h00001 : {1'b0, divInt};
  assign nxt_acc   = {1'b0, acc_ff} + {1'b0, divFrac};
  assign periodEnd = prescTick && (cnt_ff >= len_ff - 17'h00001);

  // count prescaled ticks, reload length only at a period boundary
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_ff <= 17'h00000;
      len_ff <= 17'h00001;
      acc_ff <= 4'h0;
    end else if (periodEnd) begin
      cnt_ff <= 17'h00000;
      acc_ff <= nxt_acc[3:0];
      len_ff <= effInt + {16'h0000, nxt_acc[4]};
    end else if (prescTick) begin
      cnt_ff <= cnt_ff + 17'h00001;
    end
  end

  // one-cycle sampling pulse per period
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= periodEnd;
    end
  end

  assign sampleTick = tick_ff;

endmodule

/* design/fbg_uart_tx.sv */
`timescale 1ns/1ps
module fbg_uart_tx (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // host register port
  input  wire logic       csN,
  input  wire logic       wrN,
  input  wire logic       rdN,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData,
  // serial line and sampling clock
  output logic            txOut,
  output logic            rxSampleTick
);
  import fbg_pkg::*;

  logic [7:0] divLow_ff;
  logic [7:0] divHigh_ff;
  logic [7:0] divFrac_ff;
  logic [7:0] eightX_ff;
  logic [7:0] fourX_ff;
  logic [7:0] modemCtrl_ff;
  logic [7:0] lineCtrl_ff;
  logic [7:0] rdData_ff;
  logic [1:0] presc_ff;
  logic       hostWr;
  logic       hostRd;
  logic       prescTick;
  logic       sampleTick;
  logic [4:0] ovsRatio;

  logic [7:0]           fifoMem [FBG_FIFO_DEPTH];
  logic [FBG_PTR_W-1:0] wrPtr_ff;
  logic [FBG_PTR_W-1:0] rdPtr_ff;
  logic [4:0]           fifoCnt_ff;
  logic                 fifoPush;
  logic                 fifoPop;

  logic [7:0] buf0_ff;
  logic [7:0] buf1_ff;
  logic [1:0] bufCnt_ff;
  logic       bufInValid;
  logic       bufInReady;
  logic       bufOutValid;
  logic       bufOutReady;

  fbg_tx_state_t state_ff;
  logic [7:0]    shift_ff;
  logic [2:0]    bitCnt_ff;
  logic [4:0]    tickCnt_ff;
  logic          stopCnt_ff;
  logic          parity_ff;
  logic          txOut_ff;
  logic          bitEnd;
  logic [2:0]    lastBit;
  logic          thrEmpty;
  logic          txEmpty;

  // masks unused upper bits for short words and returns the data parity
  function automatic logic dataParity(input logic [7:0] d, input logic [1:0] wl);
    logic [7:0] mask;
    mask = 8'hFF >> (3'h3 - {1'b0, wl});
    return ^(d & mask);
  endfunction

  // host strobes, one access per cycle of strobe
  assign hostWr = !csN && !wrN;
  assign hostRd = !csN && !rdN;

  // divisor and fraction registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      divLow_ff  <= FBG_RST_DIV_LOW;
      divHigh_ff <= FBG_RST_DIV_HIGH;
      divFrac_ff <= FBG_RST_DIV_FRAC;
    end else if (hostWr) begin
      if (addr == FBG_OFS_DIV_LOW) begin
        divLow_ff <= wrData;
      end
      if (addr == FBG_OFS_DIV_HIGH) begin
        divHigh_ff <= wrData;
      end
      if (addr == FBG_OFS_DIV_FRAC) begin
        divFrac_ff <= {4'h0, wrData[FBG_FRAC_W-1:0]};
      end
    end
  end

  // mode, modem control and line control registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      eightX_ff    <= FBG_RST_MODE;
      fourX_ff     <= FBG_RST_MODE;
      modemCtrl_ff <= FBG_RST_MODEM;
      lineCtrl_ff  <= FBG_RST_LINE_CTRL;
    end else if (hostWr) begin
      if (addr == FBG_OFS_EIGHT_X) begin
        eightX_ff <= wrData;
      end
      if (addr == FBG_OFS_FOUR_X) begin
        fourX_ff <= wrData;
      end
      if (addr == FBG_OFS_MODEM_CTRL) begin
        modemCtrl_ff <= wrData;
      end
      if (addr == FBG_OFS_LINE_CTRL) begin
        lineCtrl_ff <= wrData;
      end
    end
  end

  // read data, registered one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdData_ff <= 8'h00;
    end else if (hostRd) begin
      case (addr)
        FBG_OFS_LINE_CTRL:   rdData_ff <= lineCtrl_ff;
        FBG_OFS_DIV_LOW:     rdData_ff <= divLow_ff;
        FBG_OFS_DIV_HIGH:    rdData_ff <= divHigh_ff;
        FBG_OFS_DIV_FRAC:    rdData_ff <= divFrac_ff;
        FBG_OFS_LINE_STATUS: rdData_ff <= {1'b0, txEmpty, thrEmpty, 5'h00};
        FBG_OFS_MODEM_CTRL:  rdData_ff <= modemCtrl_ff;
        FBG_OFS_EIGHT_X:     rdData_ff <= eightX_ff;
        FBG_OFS_FOUR_X:      rdData_ff <= fourX_ff;
        default:             rdData_ff <= 8'h00;
      endcase
    end
  end

  assign rdData = rdData_ff;

  // prescaler on the oscillator clock: every cycle, or every fourth
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      presc_ff <= 2'h0;
    end else begin
      presc_ff <= presc_ff + 2'h1;
    end
  end

  assign prescTick = modemCtrl_ff[FBG_MCR_PRESC_BIT] ?
                     (presc_ff == FBG_PRESC_LAST) : 1'b1;

  // this channel's own generator, shared by tx and rx
  fbg_baud_gen u_baud_gen (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .prescTick  (prescTick),
    .divInt     ({divHigh_ff, divLow_ff}),
    .divFrac    (divFrac_ff[FBG_FRAC_W-1:0]),
    .sampleTick (sampleTick)
  );

  assign rxSampleTick = sampleTick;

  // sampling ratio; reserved and other codes fall back to 16X
  always_comb begin
    if (eightX_ff == FBG_MODE_ON && fourX_ff == FBG_RST_MODE) begin
      ovsRatio = FBG_OVS_8;
    end else if (fourX_ff == FBG_MODE_ON && eightX_ff == FBG_RST_MODE) begin
      ovsRatio = FBG_OVS_4;
    end else begin
      ovsRatio = FBG_OVS_16;
    end
  end

  // transmit FIFO, writes to a full FIFO are dropped
  assign fifoPush   = hostWr && (addr == FBG_OFS_TX_HOLD) && (fifoCnt_ff != FBG_FIFO_FULL);
  assign bufInValid = (fifoCnt_ff != 5'h00);
  assign fifoPop    = bufInValid && bufInReady;

  always_ff @(posedge mclk) begin
    if (fifoPush) begin
      fifoMem[wrPtr_ff] <= wrData;
    end
  end

  // FIFO pointers and fill level
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPtr_ff   <= '0;
      rdPtr_ff   <= '0;
      fifoCnt_ff <= 5'h00;
    end else begin
      if (fifoPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (fifoPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      case ({fifoPush, fifoPop})
        2'b10:   fifoCnt_ff <= fifoCnt_ff + 5'h01;
        2'b01:   fifoCnt_ff <= fifoCnt_ff - 5'h01;
        default: fifoCnt_ff <= fifoCnt_ff;
      endcase
    end
  end

  // two-entry buffer between FIFO head and the shifter
  assign bufInReady  = (bufCnt_ff != FBG_BUF_FULL);
  assign bufOutValid = (bufCnt_ff != 2'h0);
  assign bufOutReady = (state_ff == FBG_TX_IDLE);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      buf0_ff   <= 8'h00;
      buf1_ff   <= 8'h00;
      bufCnt_ff <= 2'h0;
    end else begin
      case ({fifoPop, bufOutValid && bufOutReady})
        2'b10: begin
          if (bufCnt_ff == 2'h0) begin
            buf0_ff <= fifoMem[rdPtr_ff];
          end else begin
            buf1_ff <= fifoMem[rdPtr_ff];
          end
          bufCnt_ff <= bufCnt_ff + 2'h1;
        end
        2'b01: begin
          buf0_ff   <= buf1_ff;
          bufCnt_ff <= bufCnt_ff - 2'h1;
        end
        2'b11: begin
          if (bufCnt_ff == 2'h1) begin
            buf0_ff <= fifoMem[rdPtr_ff];
          end else begin
            buf0_ff <= buf1_ff;
            buf1_ff <= fifoMem[rdPtr_ff];
          end
        end
        default: bufCnt_ff <= bufCnt_ff;
      endcase
    end
  end

  // bit timing: a bit ends after ovsRatio sampling pulses
  assign bitEnd  = sampleTick && (tickCnt_ff >= ovsRatio - 5'h01);
  assign lastBit = {1'b0, lineCtrl_ff[1:0]} + 3'h4;     // word length 5..8 minus one

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tickCnt_ff <= 5'h00;
    end else if (state_ff == FBG_TX_IDLE || bitEnd) begin
      tickCnt_ff <= 5'h00;
    end else if (sampleTick) begin
      tickCnt_ff <= tickCnt_ff + 5'h01;
    end
  end

  // character framing state machine
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_ff   <= FBG_TX_IDLE;
      shift_ff   <= 8'h00;
      bitCnt_ff  <= 3'h0;
      stopCnt_ff <= 1'b0;
      parity_ff  <= 1'b0;
    end else begin
      case (state_ff)
        FBG_TX_IDLE: begin
          if (bufOutValid) begin
            state_ff  <= FBG_TX_START;
            shift_ff  <= buf0_ff;
            bitCnt_ff <= 3'h0;
            parity_ff <= dataParity(buf0_ff, lineCtrl_ff[1:0]) ^
                         !lineCtrl_ff[FBG_LCR_EVEN_BIT];
          end
        end
        FBG_TX_START: begin
          if (bitEnd) begin
            state_ff <= FBG_TX_DATA;
          end
        end
        FBG_TX_DATA: begin
          if (bitEnd) begin
            shift_ff  <= {1'b0, shift_ff[7:1]};
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (bitCnt_ff == lastBit) begin
              stopCnt_ff <= 1'b0;
              state_ff   <= lineCtrl_ff[FBG_LCR_PAR_BIT] ? FBG_TX_PARITY : FBG_TX_STOP;
            end
          end
        end
        FBG_TX_PARITY: begin
          if (bitEnd) begin
            state_ff <= FBG_TX_STOP;
          end
        end
        FBG_TX_STOP: begin
          if (bitEnd) begin
            stopCnt_ff <= 1'b1;
            if (stopCnt_ff || !lineCtrl_ff[FBG_LCR_STOP2_BIT]) begin
              state_ff <= FBG_TX_IDLE;
            end
          end
        end
        default: state_ff <= FBG_TX_IDLE;
      endcase
    end
  end

  // serial output, registered, idles high
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      txOut_ff <= 1'b1;
    end else begin
      case (state_ff)
        FBG_TX_START:  txOut_ff <= 1'b0;
        FBG_TX_DATA:   txOut_ff <= shift_ff[0];
        FBG_TX_PARITY: txOut_ff <= parity_ff;
        default:       txOut_ff <= 1'b1;
      endcase
    end
  end

  assign txOut = txOut_ff;

  // status: holding side empty, and whole transmitter empty
  assign thrEmpty = (fifoCnt_ff == 5'h00) && (bufCnt_ff == 2'h0);
  assign txEmpty  = thrEmpty && (state_ff == FBG_TX_IDLE);

endmodule

/* tb/fbg_uart_tx_chk.sv */
`timescale 1ns/1ps
module fbg_uart_tx_chk (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // host register port
  input wire logic       csN,
  input wire logic       wrN,
  input wire logic       rdN,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  // serial side
  input wire logic       txOut,
  input wire logic       rxSampleTick
);
  import fbg_pkg::*;
  logic prescOn_ff;
  wire  rdReq = !csN && !rdN;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // prescaler select as last written on the bus
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prescOn_ff <= 1'b0;
    end else if (!csN && !wrN && addr == FBG_OFS_MODEM_CTRL) begin
      prescOn_ff <= wrData[FBG_MCR_PRESC_BIT];
    end
  end
  // outputs leave reset quiet
  property p_rst_out; $rose(reset_n) |-> rdData == 8'h00 && txOut && !rxSampleTick; endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
  property p_rd_hold; !rdReq |=> $stable(rdData); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_unmapped; rdReq && addr > FBG_OFS_FOUR_X |=> rdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_frac_hi; rdReq && addr == FBG_OFS_DIV_FRAC |=> rdData[7:4] == 4'h0; endproperty
  a_frac_hi: assert property (p_frac_hi) else $error("fraction upper bits set");
  property p_status;
    rdReq && addr == FBG_OFS_LINE_STATUS |=> !rdData[FBG_LSR_TEMT_BIT] || rdData[FBG_LSR_THRE_BIT];
  endproperty
  a_status: assert property (p_status) else $error("shifter empty while fifo busy");
  property p_low_len; $fell(txOut) |-> !txOut [*4]; endproperty
  a_low_len: assert property (p_low_len) else $error("low bit too short");
  property p_high_len; $rose(txOut) |-> txOut [*4]; endproperty
  a_high_len: assert property (p_high_len) else $error("high bit too short");
  property p_presc;
    prescOn_ff && $past(prescOn_ff, 4) && rxSampleTick |=> !rxSampleTick [*3];
  endproperty
  a_presc: assert property (p_presc) else $error("ticks closer than four cycles");
endmodule

/* tb/fbg_line_rx.sv */
`timescale 1ns/1ps
module fbg_line_rx (
  // line side
  input  wire logic        mclk,
  input  wire logic        txOut,
  // frame format
  input  wire logic [15:0] bitCyc,
  input  wire logic [15:0] dataBits,
  input  wire logic        parOn,
  // results
  output logic      [8:0]  rxWord,
  output logic      [7:0]  rxCount,
  output logic      [7:0]  frameErrs
);
  // remote receiver sampling each bit at its middle
  initial begin
    rxCount = 8'h00;
    frameErrs = 8'h00;
    rxWord = 9'h000;
    forever begin
      @(negedge txOut);
      repeat (bitCyc / 2) @(posedge mclk);
      if (txOut !== 1'b0) frameErrs++;
      rxWord = 9'h000;
      for (int i = 0; i < int'(dataBits) + int'(parOn); i++) begin
        repeat (bitCyc) @(posedge mclk);
        rxWord[i] = txOut;
      end
      repeat (bitCyc) @(posedge mclk);
      if (txOut !== 1'b1) frameErrs++;
      rxCount++;
    end
  end
endmodule

/* tb/fbg_uart_tx_test.sv */
`timescale 1ns/1ps
module fbg_uart_tx_test;
  import fbg_pkg::*;
  logic        mclk, reset_n, csN, wrN, rdN, txOut, rxSampleTick, parOn;
  logic [3:0]  addr;
  logic [7:0]  wrData, rdData, rxCount, frameErrs;
  logic [8:0]  rxWord;
  logic [15:0] bitCyc, dataBits;
  int          failCount, comparisons, cycles;

  fbg_uart_tx u_dut (.mclk(mclk), .reset_n(reset_n), .csN(csN), .wrN(wrN), .rdN(rdN),
    .addr(addr), .wrData(wrData), .rdData(rdData), .txOut(txOut), .rxSampleTick(rxSampleTick));
  fbg_line_rx u_far (.mclk(mclk), .txOut(txOut), .bitCyc(bitCyc), .dataBits(dataBits),
    .parOn(parOn), .rxWord(rxWord), .rxCount(rxCount), .frameErrs(frameErrs));

  // clock source
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failCount++;
      completeRun();
    end
  end

  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // host bus cycles: one edge of request, released on the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    csN <= 1'b0;
    wrN <= 1'b0;
    addr <= a;
    wrData <= d;
    @(posedge mclk);
    csN <= 1'b1;
    wrN <= 1'b1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge mclk);
    csN <= 1'b0;
    rdN <= 1'b0;
    addr <= a;
    @(posedge mclk);
    csN <= 1'b1;
    rdN <= 1'b1;
    #1 chk(9'(rdData & m), 9'(exp));
  endtask
  task automatic waitRx(output logic got);
    logic [7:0] start;
    start = rxCount;
    got = 1'b0;
    for (int i = 0; i < 2000 && !got; i++) begin
      @(posedge mclk);
      got = (rxCount != start);
    end
  endtask
  // one character, compared with what the remote end decoded
  task automatic sendFrame(input logic [7:0] d, input logic [7:0] lcr, input int bc);
    logic [8:0] exp;
    logic       got;
    int         n;
    n = int'(lcr[1:0]) + 5;
    exp = 9'(d & 8'((1 << n) - 1));
    exp[n] = lcr[3] & ~(lcr[4] ^ (^exp[7:0]));
    bitCyc = 16'(bc);
    dataBits = 16'(n);
    parOn = lcr[3];
    wr(FBG_OFS_LINE_CTRL, lcr);
    wr(FBG_OFS_TX_HOLD, d);
    waitRx(got);
    chk(rxWord, exp);
    chk(9'(frameErrs), 9'h000);
  endtask
  task automatic rate(input logic [7:0] e8, input logic [7:0] f4, input logic [7:0] dl,
                      input logic [7:0] fr, input logic [7:0] mc, input int bc);
    wr(FBG_OFS_EIGHT_X, e8);
    wr(FBG_OFS_FOUR_X, f4);
    wr(FBG_OFS_DIV_LOW, dl);
    wr(FBG_OFS_DIV_FRAC, fr);
    wr(FBG_OFS_MODEM_CTRL, mc);
    sendFrame(dl ^ e8 ^ 8'h96, 8'h03, bc);
  endtask
  task automatic testResetValues();
    rdc(FBG_OFS_DIV_LOW, 8'h01, 8'hFF);
    rdc(FBG_OFS_DIV_HIGH, 8'h00, 8'hFF);
    rdc(FBG_OFS_DIV_FRAC, 8'h00, 8'hFF);
    rdc(FBG_OFS_LINE_STATUS, 8'h60, 8'h60);
    rdc(4'hF, 8'h00, 8'hFF);
  endtask
  task automatic testRates();
    rate(8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 16);
    rate(8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8);
    rate(8'h00, 8'hFF, 8'h01, 8'h00, 8'h00, 4);
    rate(8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 16);
    rate(8'h00, 8'hFF, 8'h03, 8'h00, 8'h00, 12);
    rate(8'h00, 8'hFF, 8'h01, 8'h00, 8'h80, 16);
    rate(8'h00, 8'h00, 8'h01, 8'h08, 8'h00, 24);
    rate(8'hFF, 8'h00, 8'h01, 8'h08, 8'h00, 12);
  endtask
  task automatic testFormats();
    rate(8'h00, 8'hFF, 8'h01, 8'h00, 8'h00, 4);
    sendFrame(8'hC5, 8'h1B, 4);
    sendFrame(8'hC5, 8'h0B, 4);
    sendFrame(8'h3A, 8'h04, 4);
    sendFrame(8'h6E, 8'h0A, 4);
    sendFrame(8'h9D, 8'h0D, 4);
  endtask
  // fill past capacity while the line is slow, then drain in order
  task automatic testFifoFull();
    logic got;
    int   k;
    rate(8'h00, 8'hFF, 8'h10, 8'h00, 8'h00, 64);
    for (int i = 0; i < 22; i++) wr(FBG_OFS_TX_HOLD, 8'(8'h40 + i));
    rdc(FBG_OFS_LINE_STATUS, 8'h00, 8'h60);
    k = 0;
    got = 1'b1;
    while (got) begin
      waitRx(got);
      if (got) begin
        chk(rxWord, 9'(8'h40 + k));
        k++;
      end
    end
    // sixteen in the FIFO, two in the buffer, one in the shifter
    chk(9'(k), 9'h013);
    rdc(FBG_OFS_LINE_STATUS, 8'h60, 8'h60);
  endtask
  task automatic testRegisters();
    wr(FBG_OFS_DIV_FRAC, 8'hFF);
    rdc(FBG_OFS_DIV_FRAC, 8'h0F, 8'hFF);
    wr(FBG_OFS_DIV_HIGH, 8'h01);
    rdc(FBG_OFS_DIV_HIGH, 8'h01, 8'hFF);
    wr(FBG_OFS_EIGHT_X, 8'h5A);
    rdc(FBG_OFS_EIGHT_X, 8'h5A, 8'hFF);
  endtask

  // main sequence
  initial begin
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    addr = 4'h0;
    wrData = 8'h00;
    reset_n = 1'b0;
    bitCyc = 16'h0010;
    dataBits = 16'h0008;
    parOn = 1'b0;
    failCount = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    testResetValues();
    testRates();
    testFormats();
    testFifoFull();
    testRegisters();
    completeRun();
  end
endmodule

bind fbg_uart_tx fbg_uart_tx_chk u_chk (.mclk(mclk), .reset_n(reset_n), .csN(csN),
  .wrN(wrN), .rdN(rdN), .addr(addr), .wrData(wrData), .rdData(rdData), .txOut(txOut),
  .rxSampleTick(rxSampleTick));
